// *** pkg/plc_pkg.sv ***
package plc_pkg;

   // Register offsets (byte addresses)
   localparam logic [11:0] OFF_RAW_IRQ = 12'h050;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h054;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h058;
   localparam logic [11:0] OFF_RUN_CFG = 12'h060;
   localparam logic [11:0] OFF_XLAT = 12'h064;
   localparam logic [11:0] OFF_RUN_CFG_EXT = 12'h070;
   localparam logic [11:0] OFF_RUN_GATE = 12'h100;
   localparam logic [11:0] OFF_SLP_GATE = 12'h110;
   localparam logic [11:0] OFF_DSLP_GATE = 12'h120;
   localparam logic [11:0] OFF_DSLP_CFG = 12'h144;

   // Field positions, base and extended config, lock interrupt bit
   localparam int OSC_LSB = 4;
   localparam int CRYSTAL_SELECT_LSB = 6;
   localparam int BYPASS_BIT = 11;
   localparam int PWRDN_BIT = 13;
   localparam int USEDIV_BIT = 22;
   localparam int ACG_BIT = 27;
   localparam int DIV_LSB = 23;
   localparam int EXTSEL_BIT = 31;
   localparam int LOCK_BIT = 6;

   // Reset values
   localparam logic [31:0] RUN_CFG_RST = 32'h0780_2AC0;
   localparam logic [31:0] RUN_CFG_EXT_RST = 32'h0780_2800;
   localparam logic [31:0] RUN_GATE_RST = 32'h0000_0040;
   localparam logic [31:0] SLP_GATE_RST = 32'h0000_0040;
   localparam logic [31:0] DSLP_GATE_RST = 32'h0000_0040;
   localparam logic [31:0] DSLP_CFG_RST = 32'h0780_0000;

   // Lock-time start count and PLL fixed figures
   localparam logic [15:0] LOCK_START = 16'h1200;
   localparam int PLL_VCO_MHZ = 400;
   localparam int PLL_PREDIV = 2;
   localparam logic [2:0] RTC_REF_SRC = 3'h7;
   localparam logic [7:0] XLAT_F_BASE = 8'h31;

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP, PM_WAKE} plc_mode_t;
   typedef enum logic [1:0] {SRC_OSC, SRC_GAP, SRC_PLL} plc_src_t;

   // Effective clock configuration after base/extended select
   typedef struct packed {
      logic bypass;
      logic pwrdn;
      logic use_div;
      logic [2:0] osc_src;
      logic [5:0] div;
   } plc_clk_cfg_t;

   // Crystal number to PLL setting word
   function automatic logic [15:0] plc_translate(input logic [4:0] crystal_select);
      plc_translate = {3'h0, crystal_select, XLAT_F_BASE + {3'h0, crystal_select}};
   endfunction

   localparam logic [15:0] XLAT_RST =
      plc_translate(RUN_CFG_RST[CRYSTAL_SELECT_LSB +: 5]);

endpackage

// *** hw/plc_lock_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_lock_timer #(
   parameter int CW = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic reload,
   input wire logic osc_tick,
   input wire logic [CW-1:0] start,
   output logic locked,
   output logic lock_pulse
);
   logic [CW-1:0] cnt_reg, cnt_next;
   logic run_reg, run_next;
   logic locked_reg, locked_next;

   // Reload wins over counting, even mid-count
   always_comb begin
      cnt_next = cnt_reg;
      run_next = run_reg;
      locked_next = locked_reg;
      lock_pulse = 1'b0;
      if (reload) begin
         cnt_next = start; // [RQ7] [RQ21]
         run_next = 1'b1;
         locked_next = 1'b0; // [RQ21]
      end else if (run_reg && osc_tick) begin
         if (cnt_reg <= CW'(1)) begin
            cnt_next = '0;
            run_next = 1'b0;
            locked_next = 1'b1;
            lock_pulse = 1'b1;
         end else begin
            cnt_next = cnt_reg - CW'(1); // [RQ7]
         end
      end
   end

   // State registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         locked_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         locked_reg <= locked_next;
      end
   end

   assign locked = locked_reg;

   AST_RELOAD_LOADS: assert property ( // [RQ21]
      @(posedge ref_clk) disable iff (!rst_b)
      reload |=> (cnt_reg == start) && !locked)
      else $error("reload did not restart lock count");
   AST_NO_EARLY_LOCK: assert property ( // [RQ8]
      @(posedge ref_clk) disable iff (!rst_b)
      (run_reg && cnt_reg > CW'(1)) |=> !locked)
      else $error("lock reported before count expired");
endmodule // plc_lock_timer
`default_nettype wire

// *** hw/plc_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_clk_div #(
   parameter int DW = 8
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [DW-1:0] divisor,
   output logic tick
);
   logic [DW-1:0] cnt_reg, cnt_next;
   logic tick_reg, tick_next;

   // Wrap at divisor-1; a shrunk divisor wraps at once
   always_comb begin
      tick_next = (cnt_reg + DW'(1)) >= divisor;
      cnt_next = tick_next ? '0 : cnt_reg + DW'(1);
   end

   // Counter and tick registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

   AST_DIV_WRAP: assert property ( // [RQ20]
      @(posedge ref_clk) disable iff (!rst_b)
      tick |-> cnt_reg == '0)
      else $error("divider tick without wrap");
endmodule // plc_clk_div
`default_nettype wire

// *** hw/plc_clock_ctrl.sv ***
// What this block does
// RQ1 - PLL powered down after reset
// RQ2 - PLL output halved before system divisor
// RQ3 - Crystal change updates read-only translation
// RQ4 - Extended source 0x7 selects RTC reference
// RQ5 - Normal drives PLL output, power-down does not
// RQ6 - Relock only on real crystal change, power-up
// RQ7 - Oscillator-clocked down counter loaded with 0x1200
// RQ8 - PLL not system clock before count expires
// RQ9 - One-step enable stays on oscillator until lock
// RQ10 - Lock sets raw flag, maskable interrupt
// RQ11 - Software picks crystal within supported range
// RQ12 - Run mode uses run gating register
// RQ13 - Sleep gating register chosen by auto-gating
// RQ14 - Sleep stops CPU, keeps system clock
// RQ15 - Wait-for-interrupt sleeps; deep enable deep-sleeps
// RQ16 - Deep-sleep oscillator choice and power control
// RQ17 - Deep-sleep powers PLL down, overrides divider
// RQ18 - Restore clock before reopening stopped clocks
// RQ19 - Extended select takes fields from extended register
// RQ20 - Divisor is divider field plus one
// RQ21 - New trigger reloads counter, clears lock
// RQ22 - Glitch-free oscillator/PLL switching
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module plc_clock_ctrl #(
   parameter int GW = 32
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic main_osc_tick,
   input wire logic wait_for_irq_instr,
   input wire logic deep_sleep_en,
   input wire logic wake_irq,
   output logic pll_pwrdn,
   output logic pll_ref_rtc,
   output logic [15:0] pll_settings,
   output var plc_pkg::plc_src_t sys_src,
   output logic [7:0] sys_divisor,
   output logic sys_clk_tick,
   output logic cpu_clk_en,
   output logic [GW-1:0] periph_clk_en,
   output logic main_osc_pwrdn,
   output logic int_osc_pwrup,
   output logic [2:0] int_osc_sel,
   output logic pll_lock_irq,
   output var plc_pkg::plc_mode_t power_mode,
   output var plc_pkg::plc_clk_cfg_t active_cfg
);
   logic [31:0] cfg_reg, cfg_next, ext_reg, ext_next;
   logic [31:0] dcfg_reg, dcfg_next;
   logic [GW-1:0] rgate_reg, rgate_next, sgate_reg, sgate_next;
   logic [GW-1:0] dgate_reg, dgate_next;
   logic [15:0] xlat_reg, xlat_next;
   logic lock_raw_reg, lock_raw_next, imc_reg, imc_next;
   logic pwr_prev_reg, pwr_prev_next, ds_pll_reg, ds_pll_next;
   logic [31:0] rdata_reg, rdata_next;
   plc_pkg::plc_mode_t mode_reg, mode_next;
   plc_pkg::plc_src_t src_reg, src_next;
   plc_pkg::plc_clk_cfg_t eff;
   logic use_ext, crystal_select_chg, relock, locked, lock_pulse, want_pll;
   logic wr_cfg, pwr_up, div_tick, cfg_hit, deep_entry;
   logic [6:0] div_plus1;
   logic [5:0] div_sel;

   // Base or extended field selection
   always_comb begin
      use_ext = ext_reg[plc_pkg::EXTSEL_BIT];
      eff.use_div = cfg_reg[plc_pkg::USEDIV_BIT];
      if (use_ext) begin // [RQ19]
         eff.bypass = ext_reg[plc_pkg::BYPASS_BIT];
         eff.pwrdn = ext_reg[plc_pkg::PWRDN_BIT];
         eff.osc_src = ext_reg[plc_pkg::OSC_LSB +: 3];
         eff.div = ext_reg[plc_pkg::DIV_LSB +: 6];
      end else begin
         eff.bypass = cfg_reg[plc_pkg::BYPASS_BIT];
         eff.pwrdn = cfg_reg[plc_pkg::PWRDN_BIT];
         eff.osc_src = {1'b0, cfg_reg[plc_pkg::OSC_LSB +: 2]};
         eff.div = {2'h0, cfg_reg[plc_pkg::DIV_LSB +: 4]};
      end
   end

   // PLL reference and power
   assign pll_ref_rtc = use_ext &&
      (eff.osc_src == plc_pkg::RTC_REF_SRC); // [RQ4]
   assign pll_pwrdn = eff.pwrdn || (mode_reg == plc_pkg::PM_DEEP) ||
      (mode_reg == plc_pkg::PM_WAKE && !ds_pll_reg); // [RQ1] [RQ5] [RQ17]

   // Relock triggers: real crystal change or power-up edge
   assign wr_cfg = reg_wr && (reg_addr == plc_pkg::OFF_RUN_CFG);
   assign crystal_select_chg = wr_cfg && (reg_wdata[plc_pkg::CRYSTAL_SELECT_LSB +: 5] !=
      cfg_reg[plc_pkg::CRYSTAL_SELECT_LSB +: 5]); // [RQ6]
   assign pwr_up = pwr_prev_reg && !pll_pwrdn;
   assign relock = crystal_select_chg || pwr_up; // [RQ6]

   plc_lock_timer #(.CW(16)) u_lock (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .reload(relock),
      .osc_tick(main_osc_tick),
      .start(plc_pkg::LOCK_START),
      .locked(locked),
      .lock_pulse(lock_pulse)
   );

   // PLL eligible only when powered, unbypassed and locked; a config
   // write or deep-sleep entry drops it one edge early so the PLL
   // is never still selected once it powers down
   assign cfg_hit = wr_cfg ||
      (reg_wr && (reg_addr == plc_pkg::OFF_RUN_CFG_EXT));
   assign deep_entry = (mode_reg == plc_pkg::PM_RUN) &&
      wait_for_irq_instr && deep_sleep_en;
   assign want_pll = !eff.bypass && !pll_pwrdn && locked &&
      !relock && !cfg_hit && !deep_entry; // [RQ8] [RQ9] [RQ17]

   // Break-before-make source switch through a dead cycle
   always_comb begin
      src_next = src_reg;
      unique case (src_reg)
         plc_pkg::SRC_OSC: if (want_pll) src_next = plc_pkg::SRC_GAP;
         plc_pkg::SRC_GAP:
            src_next = want_pll ? plc_pkg::SRC_PLL : plc_pkg::SRC_OSC;
         plc_pkg::SRC_PLL: if (!want_pll) src_next = plc_pkg::SRC_GAP;
         default: src_next = plc_pkg::SRC_GAP;
      endcase // [RQ22]
   end

   // Divider field, with deep-sleep override when PLL was running
   always_comb begin
      div_sel = eff.div;
      if (mode_reg == plc_pkg::PM_DEEP && ds_pll_reg) begin // [RQ17]
         div_sel = use_ext ? dcfg_reg[plc_pkg::DIV_LSB +: 6] :
            {2'h0, dcfg_reg[plc_pkg::DIV_LSB +: 4]};
      end
      div_plus1 = {1'b0, div_sel} + 7'h01; // [RQ20]
      if (src_reg == plc_pkg::SRC_PLL)
         sys_divisor = {div_plus1, 1'b0}; // [RQ2]
      else if (eff.use_div || mode_reg == plc_pkg::PM_DEEP)
         sys_divisor = {1'b0, div_plus1};
      else
         sys_divisor = 8'h01;
   end

   plc_clk_div #(.DW(8)) u_div (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .divisor(sys_divisor),
      .tick(div_tick)
   );
   assign sys_clk_tick = div_tick && (src_reg != plc_pkg::SRC_GAP);

   // Power mode sequencing
   always_comb begin
      mode_next = mode_reg;
      ds_pll_next = ds_pll_reg;
      unique case (mode_reg)
         plc_pkg::PM_RUN: if (wait_for_irq_instr) begin // [RQ15]
            mode_next = deep_sleep_en ? plc_pkg::PM_DEEP :
               plc_pkg::PM_SLEEP;
            ds_pll_next = !eff.pwrdn;
         end
         plc_pkg::PM_SLEEP: if (wake_irq) mode_next = plc_pkg::PM_RUN;
         plc_pkg::PM_DEEP: if (wake_irq) mode_next = plc_pkg::PM_WAKE;
         plc_pkg::PM_WAKE: begin
            // Reopen clocks only once source is back; lock from
            // before deep-sleep is stale while relock starts
            if (want_pll == (src_reg == plc_pkg::SRC_PLL) &&
                src_reg != plc_pkg::SRC_GAP && !relock &&
                (!ds_pll_reg || eff.bypass || locked))
               mode_next = plc_pkg::PM_RUN; // [RQ18]
         end
      endcase
   end

   // Clock gating by mode
   always_comb begin
      cpu_clk_en = (mode_reg == plc_pkg::PM_RUN); // [RQ14]
      unique case (mode_reg)
         plc_pkg::PM_RUN: periph_clk_en = rgate_reg; // [RQ12]
         plc_pkg::PM_SLEEP: periph_clk_en =
            cfg_reg[plc_pkg::ACG_BIT] ? sgate_reg : rgate_reg; // [RQ13]
         default: periph_clk_en =
            cfg_reg[plc_pkg::ACG_BIT] ? dgate_reg : rgate_reg; // [RQ13]
      endcase
   end

   // Deep-sleep oscillator power
   assign int_osc_sel = dcfg_reg[plc_pkg::OSC_LSB +: 3];
   assign int_osc_pwrup = (mode_reg == plc_pkg::PM_DEEP) &&
      (int_osc_sel != 3'h0); // [RQ16]
   assign main_osc_pwrdn = int_osc_pwrup; // [RQ16]

   // Register writes, lock flag and read data
   always_comb begin
      cfg_next = cfg_reg;
      ext_next = ext_reg;
      dcfg_next = dcfg_reg;
      rgate_next = rgate_reg;
      sgate_next = sgate_reg;
      dgate_next = dgate_reg;
      imc_next = imc_reg;
      xlat_next = xlat_reg;
      lock_raw_next = lock_raw_reg;
      rdata_next = 32'h0000_0000;
      if (reg_wr) begin
         unique case (reg_addr)
            plc_pkg::OFF_RUN_CFG: cfg_next = reg_wdata;
            plc_pkg::OFF_RUN_CFG_EXT: ext_next = reg_wdata;
            plc_pkg::OFF_DSLP_CFG: dcfg_next = reg_wdata;
            plc_pkg::OFF_RUN_GATE: rgate_next = reg_wdata[GW-1:0];
            plc_pkg::OFF_SLP_GATE: sgate_next = reg_wdata[GW-1:0];
            plc_pkg::OFF_DSLP_GATE: dgate_next = reg_wdata[GW-1:0];
            plc_pkg::OFF_IRQ_MASK: imc_next = reg_wdata[plc_pkg::LOCK_BIT];
            plc_pkg::OFF_IRQ_CLR:
               if (reg_wdata[plc_pkg::LOCK_BIT]) lock_raw_next = 1'b0;
            default: ;
         endcase
      end
      if (crystal_select_chg)
         xlat_next = plc_pkg::plc_translate(
            reg_wdata[plc_pkg::CRYSTAL_SELECT_LSB +: 5]); // [RQ3]
      if (lock_pulse) lock_raw_next = 1'b1; // [RQ10] set beats clear
      if (reg_rd) begin
         unique case (reg_addr)
            plc_pkg::OFF_RUN_CFG: rdata_next = cfg_reg;
            plc_pkg::OFF_RUN_CFG_EXT: rdata_next = ext_reg;
            plc_pkg::OFF_DSLP_CFG: rdata_next = dcfg_reg;
            plc_pkg::OFF_XLAT: rdata_next = {16'h0000, xlat_reg};
            plc_pkg::OFF_RUN_GATE: rdata_next = 32'(rgate_reg);
            plc_pkg::OFF_SLP_GATE: rdata_next = 32'(sgate_reg);
            plc_pkg::OFF_DSLP_GATE: rdata_next = 32'(dgate_reg);
            plc_pkg::OFF_RAW_IRQ:
               rdata_next[plc_pkg::LOCK_BIT] = lock_raw_reg; // [RQ10]
            plc_pkg::OFF_IRQ_MASK:
               rdata_next[plc_pkg::LOCK_BIT] = imc_reg;
            plc_pkg::OFF_IRQ_CLR:
               rdata_next[plc_pkg::LOCK_BIT] = lock_raw_reg && imc_reg;
            default: ;
         endcase
      end
      pwr_prev_next = pll_pwrdn;
   end

   // All state registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reg <= plc_pkg::RUN_CFG_RST;
         ext_reg <= plc_pkg::RUN_CFG_EXT_RST;
         dcfg_reg <= plc_pkg::DSLP_CFG_RST;
         rgate_reg <= GW'(plc_pkg::RUN_GATE_RST);
         sgate_reg <= GW'(plc_pkg::SLP_GATE_RST);
         dgate_reg <= GW'(plc_pkg::DSLP_GATE_RST);
         xlat_reg <= plc_pkg::XLAT_RST;
         lock_raw_reg <= 1'b0;
         imc_reg <= 1'b0;
         pwr_prev_reg <= 1'b1;
         ds_pll_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         mode_reg <= plc_pkg::PM_RUN;
         src_reg <= plc_pkg::SRC_OSC;
      end else begin
         cfg_reg <= cfg_next;
         ext_reg <= ext_next;
         dcfg_reg <= dcfg_next;
         rgate_reg <= rgate_next;
         sgate_reg <= sgate_next;
         dgate_reg <= dgate_next;
         xlat_reg <= xlat_next;
         lock_raw_reg <= lock_raw_next;
         imc_reg <= imc_next;
         pwr_prev_reg <= pwr_prev_next;
         ds_pll_reg <= ds_pll_next;
         rdata_reg <= rdata_next;
         mode_reg <= mode_next;
         src_reg <= src_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign pll_settings = xlat_reg;
   assign pll_lock_irq = lock_raw_reg && imc_reg; // [RQ10]
   assign sys_src = src_reg;
   assign power_mode = mode_reg;
   assign active_cfg = eff;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_wake_done;
      mode_reg == plc_pkg::PM_WAKE ##1 mode_reg == plc_pkg::PM_RUN;
   endsequence

   AST_PLL_NEEDS_LOCK: assert property ( // [RQ8]
      src_reg == plc_pkg::SRC_PLL |-> locked && !pll_pwrdn)
      else $error("PLL selected while unlocked");
   AST_GAP_BETWEEN: assert property ( // [RQ22]
      $past(src_reg) != src_reg && src_reg != plc_pkg::SRC_GAP
      |-> $past(src_reg) == plc_pkg::SRC_GAP)
      else $error("clock source switched without dead cycle");
   AST_SAME_CRYSTAL_SELECT: assert property ( // [RQ6]
      wr_cfg && reg_wdata[plc_pkg::CRYSTAL_SELECT_LSB +: 5] ==
      cfg_reg[plc_pkg::CRYSTAL_SELECT_LSB +: 5] && !pwr_up |-> !relock)
      else $error("relock on identical crystal");
   AST_XLAT_UPD: assert property ( // [RQ3]
      crystal_select_chg |=> pll_settings ==
      plc_pkg::plc_translate($past(reg_wdata[plc_pkg::CRYSTAL_SELECT_LSB +: 5])))
      else $error("translation not updated");
   AST_LOCK_FLAG: assert property ( // [RQ10]
      lock_pulse && imc_reg |=> lock_raw_reg && pll_lock_irq)
      else $error("lock event lost");
   AST_SLEEP_CPU: assert property ( // [RQ14]
      mode_reg == plc_pkg::PM_SLEEP |-> !cpu_clk_en &&
      sys_divisor == $past(sys_divisor) || $past(src_reg) != src_reg)
      else $error("sleep changed clock or kept CPU clocked");
   AST_DEEP_PLL_OFF: assert property ( // [RQ17]
      mode_reg == plc_pkg::PM_DEEP |-> pll_pwrdn &&
      src_reg != plc_pkg::SRC_PLL ##1 1)
      else $error("PLL active in deep-sleep");
   AST_WAKE_ORDER: assert property ( // [RQ18]
      s_wake_done |-> $past(src_reg) != plc_pkg::SRC_GAP && cpu_clk_en)
      else $error("clocks reopened before source restored");
   AST_ENTRY: assert property ( // [RQ15]
      mode_reg == plc_pkg::PM_RUN && wait_for_irq_instr |=>
      mode_reg == ($past(deep_sleep_en) ? plc_pkg::PM_DEEP :
      plc_pkg::PM_SLEEP))
      else $error("wrong sleep mode entered");
endmodule // plc_clock_ctrl
`default_nettype wire

// *** verif/plc_clock_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module plc_clock_ctrl_tb;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic main_osc_tick = 1'b1;
   logic wait_for_irq_instr = 1'b0;
   logic deep_sleep_en = 1'b0;
   logic wake_irq = 1'b0;
   logic pll_pwrdn, pll_ref_rtc, sys_clk_tick, cpu_clk_en;
   logic main_osc_pwrdn, int_osc_pwrup, pll_lock_irq;
   logic [15:0] pll_settings;
   logic [7:0] sys_divisor;
   logic [31:0] periph_clk_en;
   logic [2:0] int_osc_sel;
   plc_pkg::plc_src_t sys_src;
   plc_pkg::plc_mode_t power_mode;
   plc_pkg::plc_clk_cfg_t active_cfg;
   int miscompares = 0;
   int checks_done = 0;
   logic rd_taken = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] cfg, g_run, g_slp, g_dsl;
   logic [4:0] x1;
   int n;
   logic [11:0] ra[10];
   logic [31:0] re[10];

   // Free-running reference clock
   always #2.5 ref_clk = ~ref_clk;

   plc_clock_ctrl #(.GW(32)) u_plc_clock_ctrl (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .main_osc_tick(main_osc_tick),
      .wait_for_irq_instr(wait_for_irq_instr),
      .deep_sleep_en(deep_sleep_en), .wake_irq(wake_irq),
      .pll_pwrdn(pll_pwrdn), .pll_ref_rtc(pll_ref_rtc),
      .pll_settings(pll_settings), .sys_src(sys_src),
      .sys_divisor(sys_divisor), .sys_clk_tick(sys_clk_tick),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .main_osc_pwrdn(main_osc_pwrdn), .int_osc_pwrup(int_osc_pwrup),
      .int_osc_sel(int_osc_sel), .pll_lock_irq(pll_lock_irq),
      .power_mode(power_mode), .active_cfg(active_cfg)
   );

   // Verdict and end of run
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Port value comparison
   task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t port got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read data comparison
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t read got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Expected crystal translation word
   function automatic logic [15:0] xl(input logic [4:0] x);
      return {3'h0, x, 8'h31 + {3'h0, x}};
   endfunction

   // Register write cycle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Register read cycle, expectation queued
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   // Sleep request or wake event pulse
   task automatic pulse(input logic is_wake, input logic deep);
      @(posedge ref_clk);
      wake_irq <= is_wake;
      wait_for_irq_instr <= ~is_wake;
      deep_sleep_en <= deep;
      @(posedge ref_clk);
      wake_irq <= 1'b0;
      wait_for_irq_instr <= 1'b0;
   endtask

   // Bounded wait for PLL source or run mode
   task automatic wait_st(input logic on_mode, input int bound,
                          output int cnt);
      cnt = 0;
      while (on_mode ? power_mode !== plc_pkg::PM_RUN
                     : sys_src !== plc_pkg::SRC_PLL) begin
         @(posedge ref_clk);
         #1;
         cnt++;
         if (cnt > bound) begin
            miscompares++;
            $display("[ERR] t=%0t wait got=%h exp=%h", $time, cnt, bound);
            complete_run();
         end
      end
   endtask

   // Relock duration check in cycles, one tick per cycle
   task automatic chk_lock();
      wait_st(1'b0, 32'h1300, n);
      cmp_port(32'(n >= 32'h1200 && n <= 32'h1208), 32'h1);
   endtask

   // Read data watcher
   always @(posedge ref_clk) rd_taken <= reg_rd;
   always @(negedge ref_clk) begin
      if (rd_taken && exp_q.size() > 0) begin
         cmp_rd(reg_rdata, exp_q.pop_front());
      end
      if (sys_src === plc_pkg::SRC_GAP && sys_clk_tick !== 1'b0) begin
         cmp_port(32'(sys_clk_tick), 32'h0);
      end
   end

   // Main sequence
   initial begin
      n = $urandom(32'h4f83);
      ra = '{plc_pkg::OFF_RUN_CFG, plc_pkg::OFF_RUN_CFG_EXT,
             plc_pkg::OFF_RUN_GATE, plc_pkg::OFF_SLP_GATE,
             plc_pkg::OFF_DSLP_GATE, plc_pkg::OFF_DSLP_CFG,
             plc_pkg::OFF_XLAT, plc_pkg::OFF_RAW_IRQ,
             plc_pkg::OFF_IRQ_MASK, 12'h0FC};
      re = '{plc_pkg::RUN_CFG_RST, plc_pkg::RUN_CFG_EXT_RST,
             plc_pkg::RUN_GATE_RST, plc_pkg::SLP_GATE_RST,
             plc_pkg::DSLP_GATE_RST, plc_pkg::DSLP_CFG_RST,
             {16'h0, plc_pkg::XLAT_RST}, 32'h0, 32'h0, 32'h0};
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1;
      cmp_port(32'(pll_pwrdn), 32'h1);
      cmp_port(32'(sys_src), 32'(plc_pkg::SRC_OSC));
      cmp_port(periph_clk_en, 32'h40);
      cmp_port(32'(pll_ref_rtc), 32'h0);
      wr(plc_pkg::OFF_XLAT, 32'hFFFF_FFFF);
      wr(plc_pkg::OFF_RAW_IRQ, 32'hFFFF_FFFF);
      wr(12'h0FC, 32'hFFFF_FFFF);
      foreach (ra[i]) rd(ra[i], re[i]);
      $display("test reset and read-only done");
      // One-step enable with new crystal
      x1 = 5'h10 + 5'($urandom % 8);
      cfg = plc_pkg::RUN_CFG_RST;
      cfg[plc_pkg::CRYSTAL_SELECT_LSB +: 5] = x1;
      cfg[plc_pkg::BYPASS_BIT] = 1'b0;
      cfg[plc_pkg::PWRDN_BIT] = 1'b0;
      cfg[plc_pkg::USEDIV_BIT] = 1'b1;
      cfg[plc_pkg::DIV_LSB +: 4] = 4'h3;
      wr(plc_pkg::OFF_IRQ_MASK, 32'h40);
      wr(plc_pkg::OFF_RUN_CFG, cfg);
      #1;
      cmp_port(32'(pll_pwrdn), 32'h0);
      cmp_port(32'(sys_src), 32'(plc_pkg::SRC_OSC));
      cmp_port(32'(pll_settings), 32'(xl(x1)));
      chk_lock();
      cmp_port(32'(sys_divisor), 32'h8);
      // Four system ticks in 32 cycles at divide-by-8
      n = 0;
      repeat (32) begin
         @(posedge ref_clk);
         #1;
         n += sys_clk_tick;
      end
      cmp_port(32'(n), 32'h4);
      cmp_port(32'(pll_lock_irq), 32'h1);
      rd(plc_pkg::OFF_RAW_IRQ, 32'h40);
      rd(plc_pkg::OFF_XLAT, {16'h0, xl(x1)});
      wr(plc_pkg::OFF_RUN_CFG, cfg);
      repeat (4) @(posedge ref_clk);
      rd(plc_pkg::OFF_RAW_IRQ, 32'h40);
      cmp_port(32'(sys_src), 32'(plc_pkg::SRC_PLL));
      wr(plc_pkg::OFF_IRQ_CLR, 32'h40);
      rd(plc_pkg::OFF_RAW_IRQ, 32'h0);
      cmp_port(32'(pll_lock_irq), 32'h0);
      $display("test lock done");
      // Retrigger in mid-count
      cfg[plc_pkg::CRYSTAL_SELECT_LSB] = ~x1[0];
      wr(plc_pkg::OFF_RUN_CFG, cfg);
      repeat (32'h800) @(posedge ref_clk);
      #1;
      cmp_port(32'(sys_src), 32'(plc_pkg::SRC_OSC));
      cfg[plc_pkg::CRYSTAL_SELECT_LSB] = x1[0];
      wr(plc_pkg::OFF_RUN_CFG, cfg);
      chk_lock();
      $display("test reload done");
      // Extended configuration select
      wr(plc_pkg::OFF_RUN_CFG_EXT, plc_pkg::RUN_CFG_EXT_RST | 32'h8000_0070);
      #1;
      cmp_port(32'(pll_ref_rtc), 32'h1);
      cmp_port(32'(active_cfg.osc_src), 32'h7);
      cmp_port(32'(pll_pwrdn), 32'h1);
      wr(plc_pkg::OFF_RUN_CFG_EXT, plc_pkg::RUN_CFG_EXT_RST);
      chk_lock();
      $display("test extended done");
      // Gating in run, sleep and deep-sleep
      g_run = $urandom;
      g_slp = $urandom;
      g_dsl = $urandom;
      wr(plc_pkg::OFF_RUN_GATE, g_run);
      wr(plc_pkg::OFF_SLP_GATE, g_slp);
      wr(plc_pkg::OFF_DSLP_GATE, g_dsl);
      wr(plc_pkg::OFF_DSLP_CFG, plc_pkg::DSLP_CFG_RST | 32'h10);
      cfg[plc_pkg::ACG_BIT] = 1'b1;
      wr(plc_pkg::OFF_RUN_CFG, cfg);
      #1;
      cmp_port(periph_clk_en, g_run);
      pulse(1'b0, 1'b0);
      #1;
      cmp_port(32'(power_mode), 32'(plc_pkg::PM_SLEEP));
      cmp_port(32'(cpu_clk_en), 32'h0);
      cmp_port(periph_clk_en, g_slp);
      cmp_port(32'(sys_src), 32'(plc_pkg::SRC_PLL));
      cmp_port(32'(sys_divisor), 32'h8);
      pulse(1'b1, 1'b0);
      #1;
      cmp_port(32'(power_mode), 32'(plc_pkg::PM_RUN));
      pulse(1'b0, 1'b1);
      #1;
      cmp_port(32'(power_mode), 32'(plc_pkg::PM_DEEP));
      cmp_port(32'(pll_pwrdn), 32'h1);
      cmp_port(32'(sys_divisor), 32'h10);
      cmp_port(periph_clk_en, g_dsl);
      cmp_port(32'(main_osc_pwrdn), 32'h1);
      cmp_port(32'(int_osc_pwrup), 32'h1);
      cmp_port(32'(int_osc_sel), 32'h1);
      pulse(1'b1, 1'b0);
      #1;
      cmp_port(32'(power_mode), 32'(plc_pkg::PM_WAKE));
      cmp_port(32'(cpu_clk_en), 32'h0);
      wait_st(1'b1, 32'h1400, n);
      cmp_port(32'(sys_src), 32'(plc_pkg::SRC_PLL));
      cmp_port(32'(sys_divisor), 32'h8);
      cfg[plc_pkg::ACG_BIT] = 1'b0;
      wr(plc_pkg::OFF_RUN_CFG, cfg);
      pulse(1'b0, 1'b0);
      #1;
      cmp_port(periph_clk_en, g_run);
      pulse(1'b1, 1'b0);
      $display("test power modes done");
      repeat (3) @(posedge ref_clk);
      complete_run();
   end
endmodule // plc_clock_ctrl_tb
`default_nettype wire
